// File: bench/strobe_periph_model.sv
// Peripheral model that acknowledges strobe B with an edge on strobe A
`timescale 1ns/1ps
`default_nettype none
module strobe_periph_model (
    input  wire logic       core_clk,
    input  wire logic       strobe_b_out,
    input  wire logic       act_level,
    input  wire logic       ack_rise,
    input  wire logic [7:0] ack_delay,
    output var  logic       strobe_a_in
);
    logic [7:0] cnt = 8'h00;
    initial strobe_a_in = 1'h1;
    // ------------------------------------------------------------------
    // Acknowledge after a set delay; zero delay never acknowledges
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (strobe_b_out !== act_level) begin
            cnt <= 8'h00;
            strobe_a_in <= ~ack_rise;
        end else begin
            if (cnt != 8'hff) cnt <= cnt + 8'h01;
            if (ack_delay != 8'h00 && cnt == ack_delay) strobe_a_in <= ack_rise;
        end
    end
endmodule : strobe_periph_model
`default_nettype wire

// File: bench/tb_strobe_b_pin.sv
// Self-checking testbench for the strobe B pin block
`timescale 1ns/1ps
`default_nettype none
module tb_strobe_b_pin;
    import strobe_b_pkg::*;
    logic        core_clk = 1'h0, srst = 1'h1, hsel = 1'h0, hwrite = 1'h0, bus_rw = 1'h0, addr_strobe = 1'h0;
    logic        hready, hresp, strobe_b_out, strobe_a_in, e_clk, inv_b = 1'h0, pw_on = 1'h0, ack_rise = 1'h0;
    logic        e_lvl;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, seed = 32'h0000_ff9d, got;
    logic [1:0]  htrans = 2'h0, chk_kind = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [7:0]  port_b_pins, ack_delay = 8'h00;
    logic [31:0] exp_q[$];
    int          lo_q[$], hi_q[$], bad_count = 0, checked = 0, width = 0;

    always #4 core_clk = ~core_clk;

    strobe_b_pin i_dut (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .bus_rw(bus_rw), .addr_strobe(addr_strobe), .strobe_a_in(strobe_a_in),
        .strobe_b_out(strobe_b_out), .e_clk(e_clk), .port_b_pins(port_b_pins));

    strobe_periph_model i_periph (.core_clk(core_clk), .strobe_b_out(strobe_b_out), .act_level(inv_b),
        .ack_rise(ack_rise), .ack_delay(ack_delay), .strobe_a_in(strobe_a_in));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic mism(input string m);
        bad_count++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask : mism

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    // Single AHB transfer; for a checked read d is the expected data
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic chk);
        @(posedge core_clk);
        hsel <= 1'h1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge core_clk);
        while (hready !== 1'h1) @(posedge core_clk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        if (!wr && chk) begin
            exp_q.push_back(d);
            chk_kind <= 2'h1;
        end
        @(posedge core_clk);
        while (hready !== 1'h1) @(posedge core_clk);
        chk_kind <= 2'h0;
    endtask : bus

    task automatic pin_chk(input logic v);
        @(posedge core_clk);
        exp_q.push_back({31'h0000_0000, v});
        chk_kind <= 2'h2;
        @(posedge core_clk);
        chk_kind <= 2'h0;
    endtask : pin_chk

    // Pulse watching is paused while the inactive level may be moving
    task automatic set_ctrl(input logic [31:0] v, input logic on);
        pw_on <= 1'h0;
        bus(1'h1, OFS_PARALLEL_IO_CONTROL, v, 1'h0);
        inv_b <= v[0];
        ack_rise <= v[5];
        repeat (3) @(posedge core_clk);
        pw_on <= on;
    endtask : set_ctrl

    task automatic exp_pulse(input int lo, input int hi);
        lo_q.push_back(lo);
        hi_q.push_back(hi);
    endtask : exp_pulse

    // ------------------------------------------------------------------
    // Monitor: read data, pin samples and strobe widths
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (chk_kind != 2'h0) begin
            got = (chk_kind == 2'h1) ? hrdata : {31'h0000_0000, strobe_b_out};
            checked++;
            if (got !== exp_q[0]) mism("read or pin value differs");
            void'(exp_q.pop_front());
        end
        if (!pw_on) width = 0;
        else if (strobe_b_out === inv_b) width++;
        else if (width != 0) begin
            checked++;
            if (lo_q.size() == 0) mism("unexpected strobe");
            else if (width < lo_q[0] || width > hi_q[0]) mism("strobe width out of range");
            if (lo_q.size() != 0) void'(lo_q.pop_front());
            if (hi_q.size() != 0) void'(hi_q.pop_front());
            width = 0;
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        mism("watchdog expired");
        stop_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge core_clk);
        srst <= 1'h0;
        pin_chk(1'h1);
        bus(1'h0, OFS_PARALLEL_IO_CONTROL, 32'h0000_0000, 1'h1);
        bus(1'h0, 8'h10, 32'h0000_0000, 1'h1);
        repeat (2) begin
            @(posedge core_clk);
            e_lvl = e_clk;
            repeat (2) @(posedge core_clk);
            checked++;
            if (e_clk === e_lvl) mism("e_clk not toggling every two cycles");
        end
        $display("test reset done");
        set_ctrl(32'h0000_0004, 1'h1);
        seed = lfsr(seed);
        exp_pulse(8, 8);
        bus(1'h1, OFS_OUTPUT_PORT_B_DATA, seed, 1'h0);
        bus(1'h1, OFS_OUTPUT_PORT_B_DATA, seed, 1'h0);
        repeat (16) @(posedge core_clk);
        bus(1'h0, OFS_OUTPUT_PORT_B_DATA, {24'h00_0000, seed[7:0]}, 1'h1);
        checked++;
        if (port_b_pins !== seed[7:0] || hresp !== 1'h0) mism("port B pins or response wrong");
        set_ctrl(32'h0000_0001, 1'h1);
        pin_chk(1'h0);
        exp_pulse(8, 8);
        bus(1'h1, OFS_OUTPUT_PORT_B_DATA, seed, 1'h0);
        repeat (16) @(posedge core_clk);
        $display("test simple strobe done");
        for (int i = 0; i < 2; i++) begin
            set_ctrl(32'h0000_000a | (i << 2), 1'h1);
            bus(1'h1, OFS_OUTPUT_PORT_B_DATA, seed, 1'h0);
            repeat (12) @(posedge core_clk);
            exp_pulse(8, 8);
            bus(i[0], OFS_PORT_C_LATCHED, seed, 1'h0);
            repeat (16) @(posedge core_clk);
        end
        $display("test pulsed handshake done");
        ack_delay <= 8'h14;
        for (int r = 0; r < 2; r++) begin
            set_ctrl(32'h0000_0002 | (r << 5), 1'h1);
            exp_pulse(22, 34);
            bus(1'h0, OFS_PORT_C_LATCHED, 32'h0000_0000, 1'h0);
            repeat (45) @(posedge core_clk);
        end
        $display("test interlocked done");
        ack_delay <= 8'h00;
        set_ctrl(32'h0000_0002, 1'h1);
        exp_pulse(12, 24);
        bus(1'h0, OFS_PORT_C_LATCHED, 32'h0000_0000, 1'h0);
        repeat (14) @(posedge core_clk);
        bus(1'h1, OFS_PARALLEL_IO_CONTROL, 32'h0000_000a, 1'h0);
        repeat (20) @(posedge core_clk);
        $display("test pulse select end done");
        set_ctrl(32'h0000_0010, 1'h0);
        bus(1'h0, OFS_PARALLEL_IO_CONTROL, 32'h0000_0010, 1'h1);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            addr_strobe <= 1'h1;
            bus_rw <= seed[0];
            repeat (3) @(posedge core_clk);
            pin_chk(seed[0]);
            addr_strobe <= 1'h0;
            bus_rw <= ~seed[0];
            repeat (3) @(posedge core_clk);
            pin_chk(seed[0]);
        end
        set_ctrl(32'h0000_0000, 1'h0);
        addr_strobe <= 1'h1;
        bus_rw <= 1'h0;
        repeat (3) @(posedge core_clk);
        pin_chk(1'h1);
        $display("test expanded mode done");
        if (lo_q.size() != 0) mism("expected strobe never ended");
        stop_test();
    end
endmodule : tb_strobe_b_pin
`default_nettype wire

// File: verilog/strobe_b_pin.sv
// Strobe B / read-write dual purpose pin with AHB-Lite register slave
// Contract
// RULE_01: Expanded mode drives pin with read/write level, held while address strobe low.
// RULE_02: Single-chip mode drives pin with strobe B instead.
// RULE_03: Invert bit zero makes strobe B active low, one makes it active high.
// RULE_04: Simple strobe mode starts strobe at phase-2 rise after port B write.
// RULE_05: Full-input handshake starts strobe at phase-2 rise after latched port C read.
// RULE_06: Full-output handshake starts strobe at phase-2 rise after latched port C write.
// RULE_07: Simple or pulsed mode ends strobe exactly two E periods after start.
// RULE_08: Interlocked mode ends strobe at phase-2 rise after selected strobe A edge.
// RULE_09: Writing pulse select one in handshake mode ends strobe at next phase-2 rise.
// RULE_10: Active-low begin and finish requests set and clear the strobe state.
// RULE_11: Expanded-mode flag reads zero single-chip, one expanded.
// RULE_12: After reset strobe is inactive and pin shows inactive level.
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module strobe_b_pin (
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output var  logic [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire logic                    bus_rw,
    input  wire logic                    addr_strobe,
    input  wire logic                    strobe_a_in,
    output var  logic                    strobe_b_out,
    output var  logic                    e_clk,
    output var  logic [7:0]              port_b_pins
);
    import strobe_b_pkg::*;

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    control_t      ctrl;
    logic [7:0]    port_c_data;
    addr_phase_t   dphase;
    logic          dphase_valid;
    strobe_state_t state;
    logic [1:0]    e_phase;
    logic [1:0]    e_count;
    logic          finish_pending;
    logic          rw_hold;
    logic          sa_s1;
    logic          sa_s2;
    logic          sa_s3;
    logic          sa_level;
    logic          sa_prev;

    function automatic logic hit(input logic [7:0] ofs, input logic [7:0] want);
        hit = (ofs == want);
    endfunction : hit

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire         addr_take    = hsel & htrans[1] & hready;
    wire  [7:0]  addr_ofs     = haddr[7:0];
    wire         wr_data      = dphase_valid & dphase.write;
    wire         wr_control   = wr_data & hit(dphase.offset, OFS_PARALLEL_IO_CONTROL);
    wire         wr_port_b    = wr_data & hit(dphase.offset, OFS_OUTPUT_PORT_B_DATA);
    wire         wr_port_c    = wr_data & hit(dphase.offset, OFS_PORT_C_LATCHED);
    wire         rd_port_c    = addr_take & ~hwrite & hit(addr_ofs, OFS_PORT_C_LATCHED);
    wire         ph2_rise     = (e_phase == PH2_RISE_PHASE);
    wire         strobe_on    = (state == ST_ACTIVE);
    wire  [5:0]  ctrl_new     = hwdata[5:0];

    // Start trigger chosen by mode; direction ignored in simple strobe mode
    wire trig_simple = ~ctrl.handshake_select & wr_port_b;                                   // RULE_04
    wire trig_input  = ctrl.handshake_select & ~ctrl.handshake_direction & rd_port_c;        // RULE_05
    wire trig_output = ctrl.handshake_select & ctrl.handshake_direction & wr_port_c;         // RULE_06
    wire start_trig  = trig_simple | trig_input | trig_output;

    // Filtered strobe A level and its selected active edge
    wire sa_edge     = (sa_level != sa_prev) & (sa_level == ctrl.strobe_a_rise);
    wire pulsed      = ~ctrl.handshake_select | ctrl.pulse_select;
    wire timed_end   = pulsed & (e_count == STROBE_E_PERIODS - 2'h1);                        // RULE_07
    wire ack_end     = ~pulsed & sa_edge & strobe_on;                                        // RULE_08
    wire pls_end     = wr_control & ctrl_new[POS_PULSE_SELECT] & ctrl_new[POS_HANDSHAKE_SELECT]; // RULE_09

    // Active-low requests into the strobe state
    wire strobe_b_begin_n  = ~((state == ST_ARMED) & ph2_rise);                              // RULE_10
    wire strobe_b_finish_n = ~(strobe_on & ph2_rise & (timed_end | finish_pending));         // RULE_10

    wire rw_level    = addr_strobe ? bus_rw : rw_hold;                                       // RULE_01
    wire strobe_b_out_level  = ctrl.strobe_b_invert ? strobe_on : ~strobe_on;                        // RULE_03
    wire next_pin    = ctrl.expanded_mode_flag ? rw_level : strobe_b_out_level;                      // RULE_02

    wire [31:0] status_word = {26'h000_0000, e_clk, sa_level, ctrl.expanded_mode_flag,       // RULE_11
                               strobe_b_out, state == ST_ARMED, strobe_on};
    wire [31:0] next_rdata  =
        hit(addr_ofs, OFS_PARALLEL_IO_CONTROL) ? {26'h000_0000, ctrl} :
        hit(addr_ofs, OFS_OUTPUT_PORT_B_DATA)  ? {24'h00_0000, port_b_pins} :
        hit(addr_ofs, OFS_PORT_C_LATCHED)      ? {24'h00_0000, port_c_data} :
        hit(addr_ofs, OFS_STATUS)              ? status_word : 32'h0000_0000;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dphase_valid <= 1'b0;
            dphase       <= '0;
            hrdata       <= 32'h0000_0000;
        end else if (hready) begin
            dphase_valid <= addr_take;
            dphase       <= '{write: hwrite, offset: addr_ofs};
            hrdata       <= next_rdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl        <= CONTROL_RESET;
            port_b_pins <= PORT_RESET;
            port_c_data <= PORT_RESET;
        end else begin
            if (wr_control) ctrl <= ctrl_new;
            if (wr_port_b) port_b_pins <= hwdata[7:0];
            if (wr_port_c) port_c_data <= hwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // E clock and phase-2 rise enable
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            e_phase <= 2'h0;
            e_clk   <= 1'b0;
        end else begin
            e_phase <= (e_phase == 2'(E_PERIOD_CYCLES - 1)) ? 2'h0 : e_phase + 2'h1;
            e_clk   <= (e_phase >= 2'(E_PERIOD_CYCLES / 2 - 1)) & (e_phase != 2'(E_PERIOD_CYCLES - 1));
        end
    end

    // ------------------------------------------------------------------
    // Strobe A synchroniser and level filter
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sa_s1    <= 1'b0;
            sa_s2    <= 1'b0;
            sa_s3    <= 1'b0;
            sa_level <= 1'b0;
            sa_prev  <= 1'b0;
        end else begin
            sa_s1    <= strobe_a_in;
            sa_s2    <= sa_s1;
            sa_s3    <= sa_s2;
            sa_prev  <= sa_level;
            if (sa_s2 == sa_s3) sa_level <= sa_s3;
        end
    end

    // ------------------------------------------------------------------
    // Strobe B state
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state          <= ST_IDLE;                                                       // RULE_12
            e_count        <= 2'h0;
            finish_pending <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    finish_pending <= 1'b0;
                    if (start_trig) state <= ST_ARMED;
                end
                ST_ARMED: begin
                    e_count <= 2'h0;
                    if (!strobe_b_begin_n) state <= ST_ACTIVE;                               // RULE_10
                end
                ST_ACTIVE: begin
                    if (ph2_rise) e_count <= e_count + 2'h1;
                    if (ack_end | pls_end) finish_pending <= 1'b1;                           // RULE_08
                    if (!strobe_b_finish_n) begin
                        state          <= ST_IDLE;
                        finish_pending <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin driver and read/write hold
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rw_hold      <= 1'b1;
            strobe_b_out <= 1'b1;
        end else begin
            if (addr_strobe) rw_hold <= bus_rw;
            strobe_b_out <= next_pin;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_armed_at_ph2;
        state == ST_ARMED && ph2_rise;
    endsequence

    sequence s_active_then_idle;
        state == ST_ACTIVE ##1 state == ST_IDLE;
    endsequence

    a_expanded_pin_rw: assert property (@(posedge core_clk) disable iff (srst)       // RULE_01
        ctrl.expanded_mode_flag && addr_strobe |=> strobe_b_out == $past(bus_rw))
        else $error("pin does not follow read/write level in expanded mode");

    a_single_chip_pin: assert property (@(posedge core_clk) disable iff (srst)       // RULE_02
        !ctrl.expanded_mode_flag |=> strobe_b_out == ($past(ctrl.strobe_b_invert) ~^ $past(strobe_on)))
        else $error("pin does not carry strobe B in single-chip mode");

    a_simple_start_ph2: assert property (@(posedge core_clk) disable iff (srst)      // RULE_04
        state == ST_IDLE && trig_simple |=> state == ST_ARMED ##[0:3] s_armed_at_ph2 ##1 strobe_on)
        else $error("simple strobe did not start at phase-2 rise");

    a_input_start: assert property (@(posedge core_clk) disable iff (srst)           // RULE_05
        state == ST_IDLE && trig_input |=> state == ST_ARMED)
        else $error("latched port C read did not arm strobe");

    a_output_start: assert property (@(posedge core_clk) disable iff (srst)          // RULE_06
        state == ST_IDLE && trig_output |=> state == ST_ARMED)
        else $error("latched port C write did not arm strobe");

    a_pulse_two_periods: assert property (@(posedge core_clk) disable iff (srst)     // RULE_07
        s_armed_at_ph2 ##0 (~ctrl.handshake_select) |=>
            (strobe_on && !wr_control) [*7] ##1 s_active_then_idle)
        else $error("pulsed strobe not two E periods long");

    a_interlock_end: assert property (@(posedge core_clk) disable iff (srst)         // RULE_08
        ack_end && !ph2_rise |-> ##[1:4] (ph2_rise && state == ST_ACTIVE) ##1 state == ST_IDLE)
        else $error("strobe A edge did not end interlocked strobe");

    a_pls_write_end: assert property (@(posedge core_clk) disable iff (srst)         // RULE_09
        strobe_on && pls_end && !ph2_rise |-> ##[1:4] state == ST_IDLE)
        else $error("pulse select write did not end strobe");

    a_idle_after_reset: assert property (@(posedge core_clk)                         // RULE_12
        $fell(srst) |-> state == ST_IDLE && strobe_b_out == 1'b1)
        else $error("strobe not inactive after reset");

    // ------------------------------------------------------------------
    // Strobe state, phase-2 spacing and read/write hold guards
    // ------------------------------------------------------------------
    sequence s_ph2_spacing;
        !ph2_rise [*3] ##1 ph2_rise;
    endsequence

    a_ph2_every_four: assert property (@(posedge core_clk) disable iff (srst)         // RULE_07
        ph2_rise |=> s_ph2_spacing)
        else $error("phase-2 rise not every fourth cycle");

    a_armed_waits_ph2: assert property (@(posedge core_clk) disable iff (srst)        // RULE_04
        state == ST_ARMED && !ph2_rise |=> state == ST_ARMED)
        else $error("strobe began away from phase-2 rise");

    a_armed_bounded: assert property (@(posedge core_clk) disable iff (srst)          // RULE_05
        state == ST_ARMED |-> ##[0:3] ph2_rise)
        else $error("armed strobe saw no phase-2 rise");

    a_end_only_ph2: assert property (@(posedge core_clk) disable iff (srst)           // RULE_08
        strobe_on && !ph2_rise |=> strobe_on)
        else $error("strobe ended away from phase-2 rise");

    a_begin_sets: assert property (@(posedge core_clk) disable iff (srst)             // RULE_10
        !strobe_b_begin_n |=> strobe_on)
        else $error("begin request did not set strobe");

    a_finish_clears: assert property (@(posedge core_clk) disable iff (srst)          // RULE_10
        !strobe_b_finish_n |=> state == ST_IDLE)
        else $error("finish request did not clear strobe");

    a_busy_ignores_trig: assert property (@(posedge core_clk) disable iff (srst)      // RULE_10
        strobe_on && start_trig && !ph2_rise |=> strobe_on)
        else $error("trigger disturbed an active strobe");

    a_rw_held_low_as: assert property (@(posedge core_clk) disable iff (srst)         // RULE_01
        ctrl.expanded_mode_flag && !addr_strobe |=> strobe_b_out == $past(rw_hold))
        else $error("pin lost held read/write level");

    a_pls_pending: assert property (@(posedge core_clk) disable iff (srst)            // RULE_09
        strobe_on && pls_end |=> finish_pending || state == ST_IDLE)
        else $error("pulse select write not latched as end");

    a_idle_no_pending: assert property (@(posedge core_clk) disable iff (srst)        // RULE_12
        state == ST_IDLE |=> !finish_pending)
        else $error("end request left over in idle");
endmodule : strobe_b_pin
`default_nettype wire

// File: verilog/strobe_b_pkg.sv
// Package: register map, reset values, timing counts and carrier types for the strobe B pin block
`default_nettype none
package strobe_b_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_PARALLEL_IO_CONTROL = 8'h00;
    localparam logic [7:0] OFS_OUTPUT_PORT_B_DATA  = 8'h04;
    localparam logic [7:0] OFS_PORT_C_LATCHED      = 8'h08;
    localparam logic [7:0] OFS_STATUS              = 8'h0C;

    // ------------------------------------------------------------------
    // Control field positions and reset values
    // ------------------------------------------------------------------
    localparam int POS_STROBE_B_INVERT      = 0;
    localparam int POS_HANDSHAKE_SELECT     = 1;
    localparam int POS_HANDSHAKE_DIRECTION  = 2;
    localparam int POS_PULSE_SELECT         = 3;
    localparam int POS_EXPANDED_MODE_FLAG   = 4;
    localparam int POS_STROBE_A_RISE        = 5;
    localparam logic [5:0] CONTROL_RESET    = 6'h00;
    localparam logic [7:0] PORT_RESET       = 8'h00;

    // ------------------------------------------------------------------
    // E-clock timing, in core clock cycles; strobe length in E periods
    // ------------------------------------------------------------------
    localparam int         E_PERIOD_CYCLES  = 4;
    localparam logic [1:0] PH2_RISE_PHASE   = 2'h1;
    localparam logic [1:0] STROBE_E_PERIODS = 2'h2;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic strobe_a_rise;
        logic expanded_mode_flag;
        logic pulse_select;
        logic handshake_direction;
        logic handshake_select;
        logic strobe_b_invert;
    } control_t;

    typedef struct packed {
        logic       write;
        logic [7:0] offset;
    } addr_phase_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_ACTIVE
    } strobe_state_t;
endpackage : strobe_b_pkg
`default_nettype wire
